/* hw/summary_pkg.sv */
// Overview of operation
// - 16-bit summary register at 08h; block bits 0-6 and 8-13, others zero.
// - one-second tick bit latches each second of line clock; read clears it.
// - the one-second boundary phase is arbitrary, not aligned to anything.
// - saturation bit latches on any counter saturating; read clears it anyway.
// - a summary bit drives the interrupt only when its mask bit is one.
// - tester bit sets on enabled tester event; tester status read clears it.
// - hdlc bit sets on enabled hdlc change; hdlc status read clears it.
// - far_end_alarm_code_flag bit sets on a new verified code word; far_end_alarm_code_flag status read clears.
// - tributary frame alarm bit sets on enabled change; its read clears it.
// - tributary remote alarm bit sets on enabled change; its read clears it.
// - loopback bit is one while any line carries an active command.
// - line framer bit sets on enabled framer change; its read clears it.
// - transmit clock loss is one while formatter clock is idle ~200 ns.
// - receive clock loss is one while line receive clock is idle ~200 ns.
// - both clock loss bits start set after reset, clear once clock seen.
// - bit 12 shows the live line rate select pin, never interrupts.
// - bit 13 shows the live alternate mux mode pin, never interrupts.
// - mask register at 0Ah, same layout, one unmasks, resets to zero.
package summary_pkg;

  // register indices; the byte address is four times the index
  localparam logic [7:0] SUMMARY_IDX = 8'h08;
  localparam logic [7:0] MASK_IDX = 8'h0a;
  localparam logic [7:0] SUMMARY_ADDR = 8'(SUMMARY_IDX * 4);
  localparam logic [7:0] MASK_ADDR = 8'(MASK_IDX * 4);

  localparam int BIT_TICK = 0;
  localparam int BIT_SAT = 1;
  localparam int BIT_LOOPBACK = 8;
  localparam int BIT_LINE_FRAMER = 9;
  localparam int BIT_TX_LOSS = 10;
  localparam int BIT_RX_LOSS = 11;
  localparam int BIT_RATE_PIN = 12;
  localparam int BIT_MUX_PIN = 13;

  localparam logic [15:0] IRQ_BITS = 16'h0f7f;
  localparam logic [15:0] MASK_RESET = 16'h0000;
  localparam logic [31:0] READ_UNMAPPED = 32'h0000_0000;

  localparam int CLK_PERIOD_NS = 10;
  localparam int LOSS_TIME_NS = 200;
  localparam logic [4:0] LOSS_CYCLES = 5'(LOSS_TIME_NS / CLK_PERIOD_NS);
  // line receive clock edges per second
  localparam int unsigned TICK_EDGES_DEFAULT = 44736000;

  // per-block events, enables and status-read strobes share this layout
  typedef struct packed {
    logic line_framer;
    logic trib_remote;
    logic trib_frame;
    logic far_end_alarm_code_flag;
    logic hdlc;
    logic tester;
  } block_evt_t;

endpackage

/* hw/sticky_flags.sv */
`timescale 1ns/1ns
// latched flags: a set in the clearing cycle wins, so no event is lost
module sticky_flags #(
  parameter int W = 8
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic [W-1:0] i_set,
  input wire logic [W-1:0] i_clear,
  output logic [W-1:0] o_flags
);

  logic [W-1:0] flags_reg;

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      flags_reg <= '0;
    else
      flags_reg <= (flags_reg & ~i_clear) | i_set;
  end

  assign o_flags = flags_reg;

endmodule

/* hw/master_status_summary.sv */
`timescale 1ns/1ns
module master_status_summary
  import summary_pkg::*;
#(
  parameter int unsigned TICK_EDGES = TICK_EDGES_DEFAULT
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic [7:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire block_evt_t i_evt,
  input wire block_evt_t i_evt_en,
  input wire block_evt_t i_evt_read,
  input wire logic i_counter_saturated,
  input wire logic i_loopback_active,
  input wire logic i_formatter_transmit_clock,
  input wire logic i_line_receive_clock,
  input wire logic i_line_rate_select_pin,
  input wire logic i_alt_mux_mode_pin,
  output logic o_irq
);

  function automatic logic addr_hit(input logic [7:0] a,
                                    input logic [7:0] b);
    addr_hit = (a == b);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: bit 0 tx clock, 1 rx clock, 2 rate pin, 3 mux pin

  logic [3:0] pin_meta_reg;
  logic [3:0] pin_sync_reg;
  logic [1:0] clk_prev_reg;
  logic [1:0] clk_edge;
  logic [1:0] loss_vec;

  always_ff @(posedge i_clk)
  begin
    pin_meta_reg <= {i_alt_mux_mode_pin, i_line_rate_select_pin,
                     i_line_receive_clock, i_formatter_transmit_clock};
    pin_sync_reg <= pin_meta_reg;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      clk_prev_reg <= 2'b00;
    else
      clk_prev_reg <= pin_sync_reg[1:0];
  end

  assign clk_edge = pin_sync_reg[1:0] ^ clk_prev_reg;

  ////////////////////////////////////////////////////////////////////////////
  // clock loss monitors; both clocks are judged against the system clock
  // since either one may be the clock that is missing

  genvar k;
  generate
    for (k = 0; k < 2; k++)
    begin : g_mon
      logic [4:0] idle_cnt_reg;
      logic loss_reg;

      always_ff @(posedge i_clk)
      begin
        if (i_reset)
          idle_cnt_reg <= 5'h0;
        else if (clk_edge[k])
          idle_cnt_reg <= 5'h0;
        else if (idle_cnt_reg != LOSS_CYCLES)
          idle_cnt_reg <= idle_cnt_reg + 5'h1;
      end

      always_ff @(posedge i_clk)
      begin
        if (i_reset)
          loss_reg <= 1'b1;
        else if (clk_edge[k])
          loss_reg <= 1'b0;
        else if (idle_cnt_reg == LOSS_CYCLES)
          loss_reg <= 1'b1;
      end

      assign loss_vec[k] = loss_reg;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // one-second tick counted in line receive clock edges, free phase

  logic [31:0] tick_cnt_reg;
  logic tick;

  assign tick = clk_edge[1] && pin_sync_reg[1]
                && (tick_cnt_reg == 32'(TICK_EDGES - 1));

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      tick_cnt_reg <= 32'h0000_0000;
    else if (clk_edge[1] && pin_sync_reg[1])
      tick_cnt_reg <= tick ? 32'h0000_0000 : tick_cnt_reg + 32'h0000_0001;
  end

  ////////////////////////////////////////////////////////////////////////////
  // latched summary bits: 0 tick, 1 saturation, 7:2 block events

  logic sat_prev_reg;
  logic loopback_reg;
  logic [7:0] lat_set;
  logic [7:0] lat_clear;
  logic [7:0] lat;
  logic summary_read;
  logic [15:0] summary;

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      sat_prev_reg <= 1'b0;
      loopback_reg <= 1'b0;
    end
    else
    begin
      sat_prev_reg <= i_counter_saturated;
      loopback_reg <= i_loopback_active;
    end
  end

  assign lat_set[0] = tick;
  // only a fresh saturation latches, so a read clears a standing one
  assign lat_set[1] = i_counter_saturated && !sat_prev_reg;
  assign lat_set[7:2] = i_evt & i_evt_en;
  assign lat_clear[1:0] = {2{summary_read}};
  assign lat_clear[7:2] = i_evt_read;

  sticky_flags #(
    .W(8)
  ) u_flags (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_set(lat_set),
    .i_clear(lat_clear),
    .o_flags(lat)
  );

  always_comb
  begin
    summary = 16'h0000;
    summary[6:0] = lat[6:0];
    summary[BIT_LOOPBACK] = loopback_reg;
    summary[BIT_LINE_FRAMER] = lat[7];
    summary[BIT_TX_LOSS] = loss_vec[0];
    summary[BIT_RX_LOSS] = loss_vec[1];
    summary[BIT_RATE_PIN] = pin_sync_reg[2];
    summary[BIT_MUX_PIN] = pin_sync_reg[3];
  end

  ////////////////////////////////////////////////////////////////////////////
  // avalon slave, one wait state on every access

  logic ack_reg;
  logic [31:0] rdata_reg;
  logic [15:0] mask_reg;
  logic req;
  logic mask_wr;

  assign req = i_avs_read || i_avs_write;
  assign o_avs_waitrequest = req && !ack_reg;
  assign o_avs_readdata = rdata_reg;
  // clear at the snapshot edge so an event after it stays latched
  assign summary_read = i_avs_read && !ack_reg
                        && addr_hit(i_avs_address, SUMMARY_ADDR);
  assign mask_wr = i_avs_write && ack_reg
                   && addr_hit(i_avs_address, MASK_ADDR);

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      ack_reg <= 1'b0;
    else
      ack_reg <= req && !ack_reg;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      rdata_reg <= READ_UNMAPPED;
    else if (i_avs_read && !ack_reg)
    begin
      if (addr_hit(i_avs_address, SUMMARY_ADDR))
        rdata_reg <= {16'h0000, summary};
      else if (addr_hit(i_avs_address, MASK_ADDR))
        rdata_reg <= {16'h0000, mask_reg};
      else
        rdata_reg <= READ_UNMAPPED;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      mask_reg <= MASK_RESET;
    else if (mask_wr)
    begin
      if (i_avs_byteenable[0])
        mask_reg[7:0] <= i_avs_writedata[7:0] & IRQ_BITS[7:0];
      if (i_avs_byteenable[1])
        mask_reg[15:8] <= i_avs_writedata[15:8] & IRQ_BITS[15:8];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt: registered, so it follows the summary by one cycle

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      o_irq <= 1'b0;
    else
      o_irq <= |(summary & mask_reg & IRQ_BITS);
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  a_tick_latch: assert property (@(posedge i_clk) disable iff (i_reset)
    tick |=> lat[0])
    else $error("tick did not latch");

  a_tick_read_clear: assert property (@(posedge i_clk) disable iff (i_reset)
    summary_read && !tick |=> !lat[0])
    else $error("tick bit survived a read");

  a_sat_clear: assert property (@(posedge i_clk) disable iff (i_reset)
    summary_read && i_counter_saturated && sat_prev_reg |=> !lat[1])
    else $error("saturation bit not cleared while saturated");

  a_tester_set: assert property (@(posedge i_clk) disable iff (i_reset)
    i_evt.tester && i_evt_en.tester |=> summary[2] ##1 1'b1)
    else $error("tester event lost");

  a_hdlc_clear: assert property (@(posedge i_clk) disable iff (i_reset)
    i_evt_read.hdlc && !(i_evt.hdlc && i_evt_en.hdlc) |=> !summary[3])
    else $error("hdlc bit not cleared by status read");

  a_far_end_alarm_code_flag_hold: assert property (@(posedge i_clk) disable iff (i_reset)
    summary[4] && !i_evt_read.far_end_alarm_code_flag |=> summary[4])
    else $error("far_end_alarm_code_flag bit dropped without read");

  a_irq_follows: assert property (@(posedge i_clk) disable iff (i_reset)
    o_irq == $past(|(summary & mask_reg & IRQ_BITS), 1))
    else $error("interrupt disagrees with masked summary");

  a_pins_no_irq: assert property (@(posedge i_clk) disable iff (i_reset)
    ((summary & mask_reg) & ~16'h3000) == 16'h0000 |=> !o_irq)
    else $error("pin bits raised the interrupt");

  a_loss_reset: assert property (@(posedge i_clk)
    $past(i_reset) && i_reset == 1'b0 |-> loss_vec == 2'b11)
    else $error("clock loss bits not set after reset");

  a_loss_idle: assert property (@(posedge i_clk) disable iff (i_reset)
    !clk_edge[0] [*8] ##0 g_mon[0].idle_cnt_reg == LOSS_CYCLES
    |=> loss_vec[0])
    else $error("transmit clock loss not flagged");

  a_mask_no_irq: assert property (@(posedge i_clk) disable iff (i_reset)
    mask_reg == MASK_RESET [*2] |-> !o_irq)
    else $error("interrupt with all sources masked");

  c_tick: cover property (@(posedge i_clk) disable iff (i_reset) tick);
  c_irq_rise: cover property (@(posedge i_clk) disable iff (i_reset)
    $rose(o_irq));
  c_read_summary: cover property (@(posedge i_clk) disable iff (i_reset)
    summary_read && summary[0]);
  c_tx_loss: cover property (@(posedge i_clk) disable iff (i_reset)
    $rose(loss_vec[0]));

endmodule

/* tb/master_status_summary_tb_top.sv */
`timescale 1ns/1ns
module master_status_summary_tb_top;
  import summary_pkg::*;
  logic i_clk = 1'b0;
  logic i_reset = 1'b1;
  logic [7:0] addr = 8'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] be = 4'h0;
  logic [31:0] rdata;
  logic wait_req;
  logic irq;
  block_evt_t evt = '0;
  block_evt_t en = '0;
  block_evt_t evt_rd = '0;
  logic sat = 1'b0;
  logic loop_act = 1'b0;
  logic txc = 1'b0;
  logic rxc = 1'b0;
  logic rate = 1'b0;
  logic mux = 1'b0;
  logic tx_run = 1'b0;
  logic rx_run = 1'b0;
  logic [1:0] div = 2'b00;
  logic [31:0] q;
  logic e;
  integer seed = 32'h46da80cf;
  int n_mismatch = 0;
  int comparisons = 0;
  int cyc = 0;
  int pos [6] = '{2, 3, 4, 5, 6, 9};

  master_status_summary #(.TICK_EDGES(8)) u_master_status_summary (
    .i_clk(i_clk), .i_reset(i_reset), .i_avs_address(addr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata),
    .i_avs_byteenable(be), .o_avs_readdata(rdata),
    .o_avs_waitrequest(wait_req), .i_evt(evt), .i_evt_en(en),
    .i_evt_read(evt_rd), .i_counter_saturated(sat),
    .i_loopback_active(loop_act), .i_formatter_transmit_clock(txc),
    .i_line_receive_clock(rxc), .i_line_rate_select_pin(rate),
    .i_alt_mux_mode_pin(mux), .o_irq(irq));

  ////////////////////////////////////////////////////////////////////////
  always #5 i_clk = ~i_clk;

  // link clocks toggle every 4 cycles, well under the monitor's limit
  always @(posedge i_clk)
  begin
    div <= div + 2'd1;
    if (tx_run && div == 2'd0)
      txc <= ~txc;
    if (rx_run && div == 2'd0)
      rxc <= ~rxc;
  end

  always @(posedge i_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      print_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] pin_bits(input logic r, input logic m);
    return {18'h0, m, r, 12'h000};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [3:0] b);
    int n;
    @(posedge i_clk);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= d;
    be <= b;
    n = 0;
    do
    begin
      @(posedge i_clk);
      n++;
    end
    while (wait_req !== 1'b0 && n < 50);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    chk(32'(n < 50), 32'h1);
  endtask

  task automatic rd_bit(input int p, input logic exp);
    bus(1'b0, SUMMARY_ADDR, 32'h0, 4'hf);
    chk(32'(q[p]), 32'(exp));
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge i_clk);
  endtask

  task automatic print_verdict();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    rate = 1'($random(seed));
    mux = 1'($random(seed));
    idle(3);
    i_reset <= 1'b0;
    chk(32'(irq), 32'h0);
    bus(1'b0, SUMMARY_ADDR, 32'h0, 4'hf);
    chk(q, 32'h0c00 | pin_bits(rate, mux));
    bus(1'b0, MASK_ADDR, 32'h0, 4'hf);
    chk(q, 32'(MASK_RESET));
    bus(1'b0, 8'h30, 32'h0, 4'hf);
    chk(q, READ_UNMAPPED);
    bus(1'b1, MASK_ADDR, 32'hffff_ffff, 4'h1);
    bus(1'b0, MASK_ADDR, 32'h0, 4'hf);
    chk(q, 32'h007f);
    bus(1'b1, MASK_ADDR, 32'hffff_ffff, 4'h3);
    bus(1'b0, MASK_ADDR, 32'h0, 4'hf);
    chk(q, 32'h0f7f);
    tx_run <= 1'b1;
    rx_run <= 1'b1;
    idle(40);
    bus(1'b0, SUMMARY_ADDR, 32'h0, 4'hf);
    chk(q & 32'hfffe, pin_bits(rate, mux));
    // poll for a tick, then the next read must find it clear and a read after 80 idle cycles find it set
    repeat (20)
      if (q[0] !== 1'b1)
        bus(1'b0, SUMMARY_ADDR, 32'h0, 4'hf);
    chk(32'(q[0]), 32'h1);
    rd_bit(0, 1'b0);
    idle(80);
    rd_bit(0, 1'b1);
    // event sources only, so ticks cannot disturb the output
    bus(1'b1, MASK_ADDR, 32'h027c, 4'h3);
    for (int k = 0; k < 6; k++)
    begin
      e = (k == 0) ? 1'b1 : (k == 1) ? 1'b0 : 1'($random(seed));
      @(posedge i_clk);
      evt <= block_evt_t'(6'(1 << k));
      en <= block_evt_t'(6'(e << k));
      @(posedge i_clk);
      evt <= '0;
      idle(3);
      chk(32'(irq), 32'(e));
      rd_bit(pos[k], e);
      rd_bit(pos[k], e);
      evt_rd <= block_evt_t'(6'(1 << k));
      @(posedge i_clk);
      evt_rd <= '0;
      idle(3);
      chk(32'(irq), 32'h0);
      rd_bit(pos[k], 1'b0);
    end
    bus(1'b1, MASK_ADDR, 32'h0, 4'h3);
    sat <= 1'b1;
    idle(3);
    rd_bit(1, 1'b1);
    rd_bit(1, 1'b0);
    chk(32'(irq), 32'h0);
    bus(1'b1, MASK_ADDR, 32'h0100, 4'h3);
    loop_act <= 1'b1;
    idle(4);
    rd_bit(8, 1'b1);
    rd_bit(8, 1'b1);
    chk(32'(irq), 32'h1);
    loop_act <= 1'b0;
    idle(4);
    chk(32'(irq), 32'h0);
    rd_bit(8, 1'b0);
    for (int j = 0; j < 2; j++)
    begin
      bus(1'b1, MASK_ADDR, 32'h0400 << j, 4'h3);
      if (j == 0)
        tx_run <= 1'b0;
      else
        rx_run <= 1'b0;
      idle(40);
      rd_bit(10 + j, 1'b1);
      chk(32'(irq), 32'h1);
      tx_run <= 1'b1;
      rx_run <= 1'b1;
      idle(20);
      rd_bit(10 + j, 1'b0);
      chk(32'(irq), 32'h0);
    end
    rate <= ~rate;
    mux <= ~mux;
    bus(1'b1, MASK_ADDR, 32'hffff, 4'h3);
    idle(4);
    bus(1'b0, SUMMARY_ADDR, 32'h0, 4'hf);
    chk(q & 32'hfffe_3000, pin_bits(rate, mux) & 32'h3000);
    print_verdict();
  end
endmodule
